// ==== logic/dcvs_consts.svh ====
// Purpose: Offsets, reset values and thresholds of the settings bank
// Assumes: Variable numbers used directly as 8-bit offsets
// Notes: Definitions only
`ifndef DCVS_CONSTS_SVH
`define DCVS_CONSTS_SVH
`define DCVS_OFF_RESET_TRIG 8'h08
`define DCVS_OFF_BRAKING_TIME 8'h04
`define DCVS_OFF_BACKCH_CFG 8'h1c
`define DCVS_OFF_DECODER_CFG 8'h1d
`define DCVS_OFF_BRK_THRESH 8'h40
`define DCVS_OFF_BRK_TRIM 8'h41
`define DCVS_OFF_RETENTION 8'h7a
`define DCVS_OFF_SOUND_OPT 8'h7c
`define DCVS_OFF_FADER_VOL 8'h85
`define DCVS_RESET_MAGIC 8'h08
`define DCVS_RST_BRAKING_TIME 8'h00
`define DCVS_RST_BACKCH_CFG 8'h80
`define DCVS_RST_DECODER_CFG 8'h08
`define DCVS_RST_BRK_THRESH 8'h64
`define DCVS_RST_BRK_TRIM 8'h00
`define DCVS_RST_RETENTION 8'h00
`define DCVS_RST_SOUND_OPT 8'h00
`define DCVS_RST_FADER_VOL 8'h80
`define DCVS_MIN_BRAKING_TIME 8'h14
`define DCVS_FADER_UNITY 8'h80
`define DCVS_BIT_DIRECTION 0
`define DCVS_BIT_KEEP_FUNC 0
`define DCVS_BIT_KEEP_SPEED 1
`define DCVS_BIT_BACKCH_EN 3
`define DCVS_BIT_AUTO_REG 7
`define DCVS_SPEED_MAX 8'h7f
`endif

// ==== logic/dcvs_pkg.sv ====
// Purpose: Types shared by the settings bank
// Assumes: Nothing
// Notes: Types only
package dcvs_pkg;
	typedef enum logic [1:0] {DCVS_FADE_DOWN, DCVS_FADE_UNITY,
		DCVS_FADE_UP} dcvs_fade_t;
	typedef enum logic [1:0] {DCVS_BC_IDLE, DCVS_BC_ADDR,
		DCVS_BC_CV} dcvs_bc_t;
endpackage

// ==== logic/dcvs_bank_if.sv ====
// Purpose: Write and read path to the retained storage
// Assumes: One clock
// Notes: Read data registered in the store
`timescale 1ns/1ps
interface dcvs_bank_if;
	logic we;
	logic [7:0] waddr;
	logic [7:0] wdata;
	logic [7:0] raddr;
	logic [7:0] rdata;
	modport ctrl (output we, output waddr, output wdata, output raddr,
		input rdata);
	modport store (input we, input waddr, input wdata, input raddr,
		output rdata);
endinterface

// ==== logic/dcvs_store.sv ====
// Purpose: 256-entry retained variable store, registered read
// Assumes: Store contents survive power loss in the real part
// Notes: No reset of the array; the bank tracks its own copies
`timescale 1ns/1ps
module dcvs_store
(
	input wire clock,
	dcvs_bank_if.store bus
);
	logic [7:0] mem [0:255];
	always_ff @(posedge clock)
	begin
		if (bus.we)
		begin
			mem[bus.waddr] <= bus.wdata;
		end
		bus.rdata <= mem[bus.raddr];
	end
endmodule

// ==== logic/dcvs_bank.sv ====
// Purpose: Configuration-variable bank of a sound decoder
// Assumes: Station writes and reads arrive as one-cycle strobes
// Notes: Speed in 128-step form, 0 is stop
`timescale 1ns/1ps
`include "dcvs_consts.svh"
module dcvs_bank
(
	input wire clock,
	input wire arst_n,
	input wire cv_wr,
	input wire [7:0] cv_addr,
	input wire [7:0] cv_wdata,
	input wire cv_rd,
	input wire speed_cmd,
	input wire [6:0] speed_value,
	input wire [31:0] func_cmd,
	input wire fader_on,
	input wire [7:0] master_volume,
	input wire power_up,
	input wire [6:0] saved_speed,
	input wire [31:0] saved_funcs,
	input wire broadcast_req,
	input wire [13:0] loco_address,
	input wire capable_station,
	input wire analog_to_digital,
	input wire [6:0] current_speed,
	output logic brake_sound,
	output logic [7:0] out_volume,
	output logic [1:0] fade_mode,
	output logic direction_bit,
	output logic keep_direction,
	output logic [6:0] speed_target,
	output logic [31:0] func_state,
	output logic bc_valid,
	output logic [1:0] bc_kind,
	output logic [15:0] bc_data,
	output logic auto_register,
	output logic reset_done
);
	typedef struct packed {
		logic [7:0] braking_time;
		logic [7:0] backchannel_config;
		logic [7:0] decoder_config;
		logic [7:0] brake_sound_threshold;
		logic [7:0] brake_sound_trim;
		logic [7:0] state_retention;
		logic [7:0] sound_options;
		logic [7:0] fader_volume;
		logic brake_sound;
		logic [7:0] trim_count;
		logic [7:0] out_volume;
		logic [1:0] fade_mode;
		logic direction_bit;
		logic keep_direction;
		logic [6:0] speed_target;
		logic [31:0] func_state;
		logic bc_valid;
		logic [1:0] bc_kind;
		logic [15:0] bc_data;
		logic rd_pend;
		logic rd_hit;
		logic [7:0] rd_copy;
		logic [31:0] func_seen;
		logic auto_register;
		logic reset_done;
	} dcvs_state_t;
	dcvs_state_t st;
	dcvs_state_t next_st;
	dcvs_bank_if bus ();
	dcvs_store u_store
	(
		.clock(clock),
		.bus(bus)
	);

	////////////////////////////////////////////////////////////////////
	function automatic dcvs_pkg::dcvs_fade_t fade_of(input logic [7:0] v);
		if (v < `DCVS_FADER_UNITY)
			fade_of = dcvs_pkg::DCVS_FADE_DOWN;
		else if (v == `DCVS_FADER_UNITY)
			fade_of = dcvs_pkg::DCVS_FADE_UNITY;
		else
			fade_of = dcvs_pkg::DCVS_FADE_UP;
	endfunction

	function automatic logic [7:0] scale_vol(input logic [7:0] m,
		input logic [7:0] f);
		logic [16:0] p;
		p = ({9'h000, m} * {9'h000, f}) >> 7;
		if (p > 17'h000ff)
			scale_vol = 8'hff;
		else
			scale_vol = p[7:0];
	endfunction

	// Threshold maps so that 100 is near step 48: higher value, lower speed
	function automatic logic [6:0] brake_speed(input logic [7:0] t);
		logic [8:0] s;
		s = 9'h094 - {1'b0, t};
		if (t > 8'h94)
			brake_speed = 7'h00;
		else if (s > 9'h07f)
			brake_speed = 7'h7f;
		else
			brake_speed = s[6:0];
	endfunction

	// Bank copy of a tracked variable, flag in bit 8. After a factory
	// reset the store still holds old bytes, so reads must use the copy
	function automatic logic [8:0] bank_copy(input dcvs_state_t s,
		input logic [7:0] a);
		case (a)
			`DCVS_OFF_BRAKING_TIME: bank_copy = {1'b1, s.braking_time};
			`DCVS_OFF_BACKCH_CFG: bank_copy = {1'b1, s.backchannel_config};
			`DCVS_OFF_DECODER_CFG: bank_copy = {1'b1, s.decoder_config};
			`DCVS_OFF_BRK_THRESH: bank_copy = {1'b1, s.brake_sound_threshold};
			`DCVS_OFF_BRK_TRIM: bank_copy = {1'b1, s.brake_sound_trim};
			`DCVS_OFF_RETENTION: bank_copy = {1'b1, s.state_retention};
			`DCVS_OFF_SOUND_OPT: bank_copy = {1'b1, s.sound_options};
			`DCVS_OFF_FADER_VOL: bank_copy = {1'b1, s.fader_volume};
			default: bank_copy = 9'h000;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////
	// The store sees every write, tracked or not, for readback
	assign bus.we = cv_wr;
	assign bus.waddr = cv_addr;
	assign bus.wdata = cv_wdata;
	assign bus.raddr = cv_addr;

	// One combinational pass builds the next state of the whole bank
	always_comb
	begin
		next_st = st;
		next_st.bc_valid = 1'b0;
		next_st.reset_done = 1'b0;
		next_st.rd_pend = 1'b0;
		if (cv_wr)
		begin
			case (cv_addr)
				`DCVS_OFF_BRAKING_TIME: next_st.braking_time = cv_wdata;
				`DCVS_OFF_BACKCH_CFG: next_st.backchannel_config = cv_wdata;
				`DCVS_OFF_DECODER_CFG: next_st.decoder_config = cv_wdata;
				`DCVS_OFF_BRK_THRESH: next_st.brake_sound_threshold = cv_wdata;
				`DCVS_OFF_BRK_TRIM: next_st.brake_sound_trim = cv_wdata;
				`DCVS_OFF_RETENTION: next_st.state_retention = cv_wdata;
				`DCVS_OFF_SOUND_OPT: next_st.sound_options = cv_wdata;
				`DCVS_OFF_FADER_VOL: next_st.fader_volume = cv_wdata;
				`DCVS_OFF_RESET_TRIG:
				begin
					if (cv_wdata == `DCVS_RESET_MAGIC)
					begin
						next_st.braking_time = `DCVS_RST_BRAKING_TIME;
						next_st.backchannel_config = `DCVS_RST_BACKCH_CFG;
						next_st.decoder_config = `DCVS_RST_DECODER_CFG;
						next_st.brake_sound_threshold = `DCVS_RST_BRK_THRESH;
						next_st.brake_sound_trim = `DCVS_RST_BRK_TRIM;
						next_st.state_retention = `DCVS_RST_RETENTION;
						next_st.sound_options = `DCVS_RST_SOUND_OPT;
						next_st.fader_volume = `DCVS_RST_FADER_VOL;
						next_st.reset_done = 1'b1;
					end
				end
				default: ;
			endcase
		end

		// Brake sound trigger, conditions judged at the stop command
		if (speed_cmd && speed_value == 7'h00 && !st.brake_sound)
		begin
			if (st.braking_time >= `DCVS_MIN_BRAKING_TIME
				&& current_speed >= brake_speed(st.brake_sound_threshold))
			begin
				next_st.brake_sound = 1'b1;
				next_st.trim_count = st.brake_sound_trim;
			end
		end
		// Sound holds until loco stops, then runs the trim as extra time
		if (st.brake_sound && current_speed == 7'h00)
		begin
			if (st.trim_count == 8'h00)
				next_st.brake_sound = 1'b0;
			else
				next_st.trim_count = st.trim_count - 8'h01;
		end
		if (speed_cmd && speed_value != 7'h00)
			next_st.brake_sound = 1'b0;

		// Fader decode and volume follow the bank copy one cycle late
		next_st.fade_mode = fade_of(st.fader_volume);
		if (fader_on)
			next_st.out_volume = scale_vol(master_volume, st.fader_volume);
		else
			next_st.out_volume = master_volume;
		next_st.direction_bit = st.sound_options[`DCVS_BIT_DIRECTION];
		next_st.keep_direction = analog_to_digital
			&& st.sound_options[`DCVS_BIT_DIRECTION];

		// Power return takes saved levels only where retention bits ask
		if (power_up)
		begin
			if (st.state_retention[`DCVS_BIT_KEEP_FUNC])
				next_st.func_state = saved_funcs;
			else
				next_st.func_state = 32'h00000000;
			if (st.state_retention[`DCVS_BIT_KEEP_SPEED])
				next_st.speed_target = saved_speed;
			else
				next_st.speed_target = 7'h00;
		end
		else
		begin
			// Follow the station only when it changes a function, so a
			// restored set is not wiped by the unchanged command level
			if (func_cmd != st.func_seen)
				next_st.func_state = func_cmd;
			if (speed_cmd)
				next_st.speed_target = speed_value;
		end
		next_st.func_seen = func_cmd;

		// Registration needs both a willing bank and a capable station
		next_st.auto_register = capable_station
			&& st.backchannel_config[`DCVS_BIT_AUTO_REG];

		// Read answers: one cycle for the store, one to register the reply
		if (st.decoder_config[`DCVS_BIT_BACKCH_EN])
		begin
			if (st.rd_pend)
			begin
				next_st.bc_valid = 1'b1;
				next_st.bc_kind = dcvs_pkg::DCVS_BC_CV;
				if (st.rd_hit)
					next_st.bc_data = {8'h00, st.rd_copy};
				else
					next_st.bc_data = {8'h00, bus.rdata};
			end
			else if (broadcast_req)
			begin
				next_st.bc_valid = 1'b1;
				next_st.bc_kind = dcvs_pkg::DCVS_BC_ADDR;
				next_st.bc_data = {2'b00, loco_address};
			end
			if (cv_rd)
			begin
				next_st.rd_pend = 1'b1;
				{next_st.rd_hit, next_st.rd_copy} = bank_copy(st, cv_addr);
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			// Settings return to defaults; the store array is left alone
			st <= '0;
			st.braking_time <= `DCVS_RST_BRAKING_TIME;
			st.backchannel_config <= `DCVS_RST_BACKCH_CFG;
			st.decoder_config <= `DCVS_RST_DECODER_CFG;
			st.brake_sound_threshold <= `DCVS_RST_BRK_THRESH;
			st.brake_sound_trim <= `DCVS_RST_BRK_TRIM;
			st.state_retention <= `DCVS_RST_RETENTION;
			st.sound_options <= `DCVS_RST_SOUND_OPT;
			st.fader_volume <= `DCVS_RST_FADER_VOL;
			st.fade_mode <= dcvs_pkg::DCVS_FADE_UNITY;
		end
		else
		begin
			st <= next_st;
		end
	end

	// Every output is a field of the registered state
	assign brake_sound = st.brake_sound;
	assign out_volume = st.out_volume;
	assign fade_mode = st.fade_mode;
	assign direction_bit = st.direction_bit;
	assign keep_direction = st.keep_direction;
	assign speed_target = st.speed_target;
	assign func_state = st.func_state;
	assign bc_valid = st.bc_valid;
	assign bc_kind = st.bc_kind;
	assign bc_data = st.bc_data;
	assign auto_register = st.auto_register;
	assign reset_done = st.reset_done;
endmodule

// ==== test/dcvs_bank_monitor.sv ====
// Purpose: Port checks of the settings bank
// Assumes: Bound to dcvs_bank
// Notes: Latencies follow the bank's two-stage read path
`timescale 1ns/1ps
module dcvs_bank_monitor
(
	input wire clock,
	input wire arst_n,
	input wire cv_wr,
	input wire [7:0] cv_addr,
	input wire [7:0] cv_wdata,
	input wire cv_rd,
	input wire speed_cmd,
	input wire [6:0] speed_value,
	input wire [7:0] master_volume,
	input wire broadcast_req,
	input wire [13:0] loco_address,
	input wire capable_station,
	input wire brake_sound,
	input wire [7:0] out_volume,
	input wire [1:0] fade_mode,
	input wire bc_valid,
	input wire [1:0] bc_kind,
	input wire [15:0] bc_data,
	input wire auto_register,
	input wire reset_done
);
default clocking cb @(posedge clock); endclocking
default disable iff (!arst_n);
AST_RST_CAUSE: assert property (cv_wr && cv_addr == 8'h08 &&
	cv_wdata == 8'h08 |-> ##[1:2] reset_done) else $error("no reset");
AST_RST_PULSE: assert property (reset_done && !(cv_wr &&
	cv_addr == 8'h08 && cv_wdata == 8'h08) |=> !reset_done)
	else $error("reset_done too long");
AST_CV_READ: assert property (bc_valid && bc_kind == 2'h2
	|-> $past(cv_rd, 2)) else $error("stray cv answer");
AST_BCAST: assert property (bc_valid && bc_kind == 2'h1 |->
	$past(broadcast_req) && bc_data[13:0] == $past(loco_address))
	else $error("bad address answer");
AST_BRAKE_CAUSE: assert property ($rose(brake_sound) |->
	$past(speed_cmd) && $past(speed_value) == 7'h00)
	else $error("brake without stop");
AST_BRAKE_END: assert property (speed_cmd && speed_value != 7'h00
	|=> !brake_sound) else $error("brake kept while driving");
AST_UNITY: assert property ((fade_mode == 2'h1 &&
	$stable(master_volume))[*4] |-> out_volume == master_volume)
	else $error("unity fader changed volume");
AST_AUTO_REG: assert property (!capable_station[*3]
	|-> !auto_register) else $error("register without station");
cover property ($rose(brake_sound));
cover property (bc_valid && bc_kind == 2'h2);
cover property (reset_done);
endmodule

// ==== test/dcvs_station_model.sv ====
// Purpose: Command station writing and reading variables
// Assumes: Requests raised at the falling edge
// Notes: Idle lines carry inverted last value, never a stale one
`timescale 1ns/1ps
module dcvs_station_model
(
	input wire clock,
	output logic cv_wr = 1'b0,
	output logic [7:0] cv_addr = 8'h00,
	output logic [7:0] cv_wdata = 8'h00,
	output logic cv_rd = 1'b0,
	output logic speed_cmd = 1'b0,
	output logic [6:0] speed_value = 7'h00,
	output logic broadcast_req = 1'b0
);
// Kind 0 write, 1 read, 2 speed, 3 broadcast
task automatic pulse(input logic [1:0] k, input logic [7:0] a,
	input logic [7:0] d);
	@(negedge clock);
	cv_addr = a;
	cv_wdata = d;
	speed_value = d[6:0];
	cv_wr = (k == 2'h0);
	cv_rd = (k == 2'h1);
	speed_cmd = (k == 2'h2);
	broadcast_req = (k == 2'h3);
	@(negedge clock);
	{cv_wr, cv_rd, speed_cmd, broadcast_req} = 4'h0;
	cv_addr = ~a;
	cv_wdata = ~d;
	speed_value = ~d[6:0];
endtask
endmodule

// ==== test/tb_top.sv ====
// Purpose: Self-checking bench of the settings bank
// Assumes: Station model drives the request strobes
// Notes: Levels sampled at the falling edge
`timescale 1ns/1ps
module tb_top;
logic clock = 1'b0;
logic arst_n = 1'b0;
logic cv_wr, cv_rd, speed_cmd, broadcast_req, bc_valid, brake_sound;
logic direction_bit, keep_direction, auto_register, reset_done;
logic [7:0] cv_addr, cv_wdata, out_volume;
logic [7:0] master_volume = 8'h64;
logic [6:0] speed_value, speed_target;
logic [6:0] current_speed = 7'h00;
logic [6:0] saved_speed = 7'h00;
logic [31:0] saved_funcs = 32'h0;
logic [31:0] func_cmd = 32'h0;
logic [31:0] func_state;
logic [13:0] loco_address = 14'h0a5c;
logic fader_on = 1'b0;
logic power_up = 1'b0;
logic capable_station = 1'b1;
logic analog_to_digital = 1'b0;
logic [1:0] fade_mode, bc_kind;
logic [15:0] bc_data, v;
logic [1:0] vk;
int fails = 0;
int num_checks = 0;
logic [7:0] offs [8] = '{8'h04, 8'h1c, 8'h1d, 8'h40, 8'h41, 8'h7a, 8'h7c,
	8'h85};
logic [7:0] dflt [8] = '{8'h00, 8'h80, 8'h08, 8'h64, 8'h00, 8'h00, 8'h00,
	8'h80};
logic [31:0] bk [4] = '{32'h14646401, 32'h13646400, 32'h14642800,
	32'h148c2801};
logic [31:0] fd [4] = '{32'h40643200, 32'h80646401, 32'hc0649602,
	32'hffc8ff02};
dcvs_station_model st (.clock, .cv_wr, .cv_addr, .cv_wdata, .cv_rd,
	.speed_cmd, .speed_value, .broadcast_req);
dcvs_bank uut (.clock, .arst_n, .cv_wr, .cv_addr, .cv_wdata, .cv_rd,
	.speed_cmd, .speed_value, .func_cmd, .fader_on, .master_volume,
	.power_up, .saved_speed, .saved_funcs, .broadcast_req, .loco_address,
	.capable_station, .analog_to_digital, .current_speed, .brake_sound,
	.out_volume, .fade_mode, .direction_bit, .keep_direction,
	.speed_target, .func_state, .bc_valid, .bc_kind, .bc_data,
	.auto_register, .reset_done);
always #25 clock = ~clock;
//////////////////////////////
task automatic chk(input string n, input logic [15:0] e,
	input logic [15:0] g);
	num_checks++;
	if (g !== e)
	begin
		fails++;
		$display("BAD %s exp %h got %h", n, e, g);
	end
endtask
task automatic summarize;
	$display("checks %0d fails %0d", num_checks, fails);
	if (fails == 0 && num_checks > 0)
		$display("ALL TESTS PASSED");
	else
		$display("TESTS FAILED");
	$finish;
endtask
task automatic wr(input logic [7:0] a, input logic [7:0] d);
	st.pulse(2'h0, a, d);
	repeat (2) @(negedge clock);
endtask
// Answer is kept only once; ffff means nothing came back
task automatic rd(input logic [1:0] k, input logic [7:0] a);
	v = 16'hffff;
	vk = 2'h0;
	st.pulse(k, a, 8'h00);
	repeat (6)
	begin
		if (bc_valid === 1'b1 && v === 16'hffff)
		begin
			v = bc_data;
			vk = bc_kind;
		end
		@(negedge clock);
	end
endtask
//////////////////////////////
initial
begin
	#500000;
	fails++;
	summarize;
end
initial
begin
	repeat (20) @(negedge clock);
	arst_n = 1'b1;
	@(negedge clock);
	chk("fade", 16'h1, fade_mode);
	for (int i = 0; i < 8; i++)
	begin
		rd(2'h1, offs[i]);
		chk("dflt", {8'h00, dflt[i]}, v);
		chk("kind", 16'h2, vk);
	end
	chk("auto", 16'h1, auto_register);
	capable_station = 1'b0;
	repeat (4) @(negedge clock);
	chk("auto", 16'h0, auto_register);
	capable_station = 1'b1;
	wr(8'h1c, 8'h00);
	chk("auto", 16'h0, auto_register);
	wr(8'h41, 8'h03);
	for (int i = 0; i < 4; i++)
	begin
		wr(8'h04, bk[i][31:24]);
		wr(8'h40, bk[i][23:16]);
		current_speed = bk[i][14:8];
		st.pulse(2'h2, 8'h00, bk[i][15:8]);
		st.pulse(2'h2, 8'h00, 8'h00);
		chk("brake", bk[i][0], brake_sound);
	end
	current_speed = 7'h00;
	repeat (3) @(negedge clock);
	chk("brake", 16'h1, brake_sound);
	@(negedge clock);
	chk("brake", 16'h0, brake_sound);
	fader_on = 1'b1;
	for (int i = 0; i < 4; i++)
	begin
		master_volume = fd[i][23:16];
		wr(8'h85, fd[i][31:24]);
		chk("vol", fd[i][15:8], out_volume);
		chk("mode", fd[i][1:0], fade_mode);
	end
	wr(8'h7c, 8'h01);
	chk("dir", 16'h1, direction_bit);
	analog_to_digital = 1'b1;
	@(negedge clock);
	chk("a2d", 16'h1, keep_direction);
	wr(8'h7a, 8'h03);
	saved_speed = 7'h21;
	saved_funcs = 32'ha5;
	power_up = 1'b1;
	@(negedge clock);
	power_up = 1'b0;
	repeat (2) @(negedge clock);
	chk("speed", 16'h21, speed_target);
	chk("funcs", 16'ha5, func_state[15:0]);
	rd(2'h3, 8'h00);
	chk("addr", 16'h0a5c, v);
	chk("kind", 16'h1, vk);
	wr(8'h1d, 8'h00);
	rd(2'h1, 8'h40);
	chk("off", 16'hffff, v);
	rd(2'h3, 8'h00);
	chk("off", 16'hffff, v);
	wr(8'h1d, 8'h08);
	st.pulse(2'h0, 8'h08, 8'h07);
	chk("done", 16'h0, reset_done);
	repeat (2) @(negedge clock);
	rd(2'h1, 8'h40);
	chk("keep", 16'h8c, v);
	wr(8'h1d, 8'h00);
	st.pulse(2'h0, 8'h08, 8'h08);
	chk("done", 16'h1, reset_done);
	repeat (2) @(negedge clock);
	rd(2'h1, 8'h40);
	chk("fact", 16'h64, v);
	summarize;
end
endmodule
bind dcvs_bank dcvs_bank_monitor mon (.clock, .arst_n, .cv_wr, .cv_addr,
	.cv_wdata, .cv_rd, .speed_cmd, .speed_value, .master_volume,
	.broadcast_req, .loco_address, .capable_station, .brake_sound,
	.out_volume, .fade_mode, .bc_valid, .bc_kind, .bc_data,
	.auto_register, .reset_done);
